// File: core/gpc_pkg.sv
/*
  constants shared by the counter 1 output block and its frequency divider:
  register offsets, field positions, reset values and timebase cycle counts.
  assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
// Function
// (R1) output shows terminal count, pulse or toggle
// (R2) software polarity applies to both output modes
// (R3) counter output tri-stated until software enables it
// (R4) external direction: low counts down, high up
// (R5) software direction when external input disabled
// (R6) selectable source edge; gate, output follow it
// (R7) internal timebase gate unsynchronised, one period uncertain
// (R8) 4-bit divider divides by 1 to 16
// (R9) divider input is 10 MHz or 100 kHz
// (R10) divider polarity selectable, tri-stated at power-up
// (R11) source from 20 MHz, 100 kHz or external; the 20 MHz choice counts once per 10 MHz clock here
// (R12) gate starts, stops, flags and saves count
// (R13) pulse mode asserts one source period
// (R14) output changes only at active source edge
package gpc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LOAD   = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_SAVE   = 8'h0C;
  localparam logic [7:0] OFS_FREQ   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // control register fields
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_OUTEN   = 1;
  localparam int CTRL_TOGGLE  = 2;
  localparam int CTRL_POL     = 3;
  localparam int CTRL_DIREXT  = 4;
  localparam int CTRL_DIRUP   = 5;
  localparam int CTRL_FALL    = 6;
  localparam int CTRL_SRC_LO  = 8;
  localparam int CTRL_GATE_LO = 10;
  localparam logic [11:0] CTRL_RST = 12'h010;

  // frequency register fields
  localparam int FREQ_DIV_LO = 0;
  localparam int FREQ_TB     = 4;
  localparam int FREQ_POL    = 5;
  localparam int FREQ_OUTEN  = 6;
  localparam logic [6:0] FREQ_RST = 7'h00;

  // status register fields
  localparam int STAT_TC   = 0;
  localparam int STAT_GATE = 1;
  localparam int STAT_DIO  = 2;
  localparam int STAT_GATEIN = 3;

  // source selections
  localparam logic [1:0] SRC_TB20M = 2'h0;
  localparam logic [1:0] SRC_TB100K = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // gate modes
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_LEVEL = 2'h1;
  localparam logic [1:0] GATE_START = 2'h2;
  localparam logic [1:0] GATE_SAVE = 2'h3;

  // timebases
  localparam int CLK_PERIOD_NS = 100;
  localparam int TB100K_PERIOD_NS = 10000;
  localparam int TB100K_CYCLES = TB100K_PERIOD_NS / CLK_PERIOD_NS;

  localparam int DIV_BITS = 4;

endpackage

// File: core/freq_cfg_if.sv
/*
  carrier between the counter block and its frequency divider: divider
  settings one way, the registered output pin and enable the other.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface freq_cfg_if;
  logic [3:0] divCode;
  logic       tbSlow;
  logic       pol;
  logic       outEn;
  logic       tick100k;
  logic       pinOut;
  logic       pinOe;

  modport ctl (output divCode, output tbSlow, output pol, output outEn,
               output tick100k, input pinOut, input pinOe);
  modport div (input divCode, input tbSlow, input pol, input outEn,
               input tick100k, output pinOut, output pinOe);
endinterface
`default_nettype wire

// File: core/freq_divider.sv
/*
  programmable frequency generator: a 4-bit counter dividing the chosen
  timebase enable by code+1 (1..16), with output polarity and enable.
  assumes the 10 MHz timebase is the clock itself and 100 kHz arrives as a
  one-cycle enable through the interface.
*/
`timescale 1ns/1ns
`default_nettype none
module freq_divider
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // settings and pin
  freq_cfg_if.div  cfg
);

  logic [DIV_BITS-1:0] cnt_r;
  logic                phase_r;
  logic                tbTick;
  logic [DIV_BITS-1:0] half;

  assign tbTick = cfg.tbSlow ? cfg.tick100k : 1'b1; // (R9)
  assign half   = DIV_BITS'((5'(cfg.divCode) + 5'h01) >> 1);

  // counter wraps at the code so the period is code+1 input ticks
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cnt_r <= '0;
    end else if (tbTick) begin
      cnt_r <= (cnt_r >= cfg.divCode) ? '0 : cnt_r + 4'h1; // (R8)
    end
  end

  // divide by one can only be a pulse per input tick at this clock rate
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phase_r <= 1'b0;
    end else if (cfg.divCode == 4'h0) begin
      phase_r <= tbTick; // (R8)
    end else if (tbTick) begin
      phase_r <= (cnt_r < half); // (R8)
    end
  end

  // pin stays released until software enables it
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfg.pinOut <= 1'b0;
      cfg.pinOe  <= 1'b0; // (R10)
    end else begin
      cfg.pinOut <= phase_r ^ cfg.pol; // (R10)
      cfg.pinOe  <= cfg.outEn; // (R10)
    end
  end

endmodule
`default_nettype wire

// File: core/gp_counter_output_freq_divider.sv
/*
  general-purpose counter 1 with its output pin, direction input, gate and
  source selection, plus the frequency generator, behind an APB slave.
  assumes pins arrive asynchronously to the 10 MHz clock and that the
  pin pads combine data and enable outside this block.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module gp_counter_output_freq_divider
  import gpc_pkg::*;
#(
  parameter int CW = 24
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // field pins
  input  wire logic        counter1_clock_source,
  input  wire logic        counter1_gate_input,
  input  wire logic        digital_line_seven,
  output var  logic        counter1_result_output,
  output var  logic        counter1_result_oe,
  output var  logic        divided_clock_output,
  output var  logic        divided_clock_oe
);

  // reset release through two flops
  logic rstMeta_r;
  logic rstSync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // register decode, shared by read and write paths
  function automatic logic [2:0] regIndex(input logic [7:0] a);
    case (a)
      OFS_CTRL:   regIndex = 3'h1;
      OFS_LOAD:   regIndex = 3'h2;
      OFS_COUNT:  regIndex = 3'h3;
      OFS_SAVE:   regIndex = 3'h4;
      OFS_FREQ:   regIndex = 3'h5;
      OFS_STATUS: regIndex = 3'h6;
      default:    regIndex = 3'h0;
    endcase
  endfunction

  logic [11:0]   ctrl_r;
  logic [CW-1:0] load_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] save_r;
  logic [6:0]    freq_r;
  logic          tcFlag_r;
  logic          gateFlag_r;
  logic          wrStb;
  logic [2:0]    wrIdx;

  assign wrStb = psel & penable & pwrite & pready;
  assign wrIdx = regIndex(paddr);

  // pin synchronisers: first stage feeds only the second
  logic [2:0] srcSy_r;
  logic [1:0] gateSy_r;
  logic [1:0] dirSy_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      srcSy_r  <= 3'h0;
      gateSy_r <= 2'h0;
      dirSy_r  <= 2'h0;
    end else begin
      srcSy_r  <= {srcSy_r[1:0], counter1_clock_source};
      gateSy_r <= {gateSy_r[0], counter1_gate_input};
      dirSy_r  <= {dirSy_r[0], digital_line_seven};
    end
  end

  // 100 kHz timebase enable shared with the divider
  localparam int PW = $clog2(TB100K_CYCLES);
  logic [PW-1:0] preCnt_r;
  logic          tick100k_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      preCnt_r   <= '0;
      tick100k_r <= 1'b0;
    end else begin
      tick100k_r <= (preCnt_r == PW'(TB100K_CYCLES - 1));
      preCnt_r   <= (preCnt_r == PW'(TB100K_CYCLES - 1)) ?
                    '0 : preCnt_r + PW'(1);
    end
  end

  // active source edge; the fast timebase is capped at one per clock
  logic [1:0] srcSel;
  logic       extRise;
  logic       extFall;
  logic       srcTick;
  assign srcSel  = ctrl_r[CTRL_SRC_LO +: 2];
  assign extRise = srcSy_r[1] & ~srcSy_r[2];
  assign extFall = ~srcSy_r[1] & srcSy_r[2];
  always_comb begin
    case (srcSel)
      SRC_TB20M:  srcTick = 1'b1; // (R11)
      SRC_TB100K: srcTick = tick100k_r; // (R11)
      SRC_EXT:    srcTick = ctrl_r[CTRL_FALL] ? extFall : extRise; // (R6)
      default:    srcTick = 1'b0;
    endcase
  end

  // gate sampled only at the active source edge; against an internal
  // timebase it is free-running, so a late change lands one edge later
  logic gateSmp_r;
  logic gateRise;
  assign gateRise = srcTick & gateSy_r[1] & ~gateSmp_r; // (R7)
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      gateSmp_r <= 1'b0;
    end else if (srcTick) begin
      gateSmp_r <= gateSy_r[1]; // (R6)
    end
  end

  // gate modes: level enable, start on edge, or save on edge
  logic [1:0] gateMode;
  logic       started_r;
  logic       countEn;
  assign gateMode = ctrl_r[CTRL_GATE_LO +: 2];
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      started_r <= 1'b0;
    end else if (!ctrl_r[CTRL_RUN]) begin
      started_r <= 1'b0;
    end else if (gateRise) begin
      started_r <= 1'b1; // (R12)
    end
  end
  always_comb begin
    case (gateMode)
      GATE_LEVEL: countEn = gateSy_r[1]; // (R12)
      GATE_START: countEn = started_r | gateRise; // (R12)
      default:    countEn = 1'b1;
    endcase
  end

  // direction from the pin or from software
  logic countUp;
  assign countUp = ctrl_r[CTRL_DIREXT] ? dirSy_r[1] // (R4)
                                       : ctrl_r[CTRL_DIRUP]; // (R5)

  // terminal count at the end of the range in the counting direction
  logic step;
  logic tcHit;
  assign step  = srcTick & ctrl_r[CTRL_RUN] & countEn;
  assign tcHit = step & (countUp ? (count_r == {CW{1'b1}})
                                 : (count_r == '0));

  // counter: a load write wins over a source edge in the same cycle
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_r <= '0;
    end else if (wrStb && wrIdx == 3'h2) begin
      count_r <= pwdata[CW-1:0];
    end else if (tcHit) begin
      count_r <= load_r;
    end else if (step) begin
      count_r <= countUp ? count_r + CW'(1) : count_r - CW'(1); // (R4)
    end
  end

  // saved count on a gate edge
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      save_r <= '0;
    end else if (gateRise && gateMode != GATE_NONE) begin
      save_r <= count_r; // (R12)
    end
  end

  // output state moves only on active source edges
  logic pulse_r;
  logic tog_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pulse_r <= 1'b0;
      tog_r   <= 1'b0;
    end else if (srcTick) begin
      pulse_r <= tcHit; // (R13)
      if (tcHit) begin
        tog_r <= ~tog_r; // (R1)
      end
    end
  end

  // pin driver; released until software enables it
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      counter1_result_output <= 1'b0;
      counter1_result_oe     <= 1'b0; // (R3)
    end else begin
      counter1_result_output <= ctrl_r[CTRL_POL] ^ // (R2)
          (ctrl_r[CTRL_TOGGLE] ? tog_r : pulse_r); // (R1) (R14)
      counter1_result_oe     <= ctrl_r[CTRL_OUTEN]; // (R3)
    end
  end

  // control, load and divider settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrl_r <= CTRL_RST;
      load_r <= '0;
      freq_r <= FREQ_RST;
    end else if (wrStb) begin
      case (wrIdx)
        3'h1:    ctrl_r <= pwdata[11:0];
        3'h2:    load_r <= pwdata[CW-1:0];
        3'h5:    freq_r <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  logic clrTc;
  logic clrGate;
  assign clrTc   = wrStb & (wrIdx == 3'h6) & pwdata[STAT_TC];
  assign clrGate = wrStb & (wrIdx == 3'h6) & pwdata[STAT_GATE];
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      tcFlag_r   <= 1'b0;
      gateFlag_r <= 1'b0;
    end else begin
      tcFlag_r   <= tcHit | (tcFlag_r & ~clrTc);
      gateFlag_r <= gateRise | (gateFlag_r & ~clrGate); // (R12)
    end
  end

  // read mux; the shared digital line reads here when freed
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (regIndex(paddr))
      3'h1:    rdMux[11:0]   = ctrl_r;
      3'h2:    rdMux[CW-1:0] = load_r;
      3'h3:    rdMux[CW-1:0] = count_r;
      3'h4:    rdMux[CW-1:0] = save_r;
      3'h5:    rdMux[6:0]    = freq_r;
      3'h6: begin
        rdMux[STAT_TC]     = tcFlag_r;
        rdMux[STAT_GATE]   = gateFlag_r;
        rdMux[STAT_DIO]    = dirSy_r[1]; // (R5)
        rdMux[STAT_GATEIN] = gateSy_r[1];
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // apb answer: data captured in setup, ready for exactly one access cycle
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (regIndex(paddr) == 3'h0);
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // frequency generator
  freq_cfg_if fcfg ();
  assign fcfg.divCode  = freq_r[FREQ_DIV_LO +: DIV_BITS];
  assign fcfg.tbSlow   = freq_r[FREQ_TB];
  assign fcfg.pol      = freq_r[FREQ_POL];
  assign fcfg.outEn    = freq_r[FREQ_OUTEN];
  assign fcfg.tick100k = tick100k_r;
  assign divided_clock_output = fcfg.pinOut;
  assign divided_clock_oe     = fcfg.pinOe;

  freq_divider u_div (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .cfg       (fcfg.div)
  );

endmodule
`default_nettype wire

// File: tb/gpc_output_properties.sv
/*
  checker for the counter 1 output block: apb handshake and pin enables.
  assumes it sees only the top ports and is bound below.
*/
`timescale 1ns/1ns
`default_nettype none
module gpc_output_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        counter1_result_output,
  input wire logic        counter1_result_oe,
  input wire logic        divided_clock_output,
  input wire logic        divided_clock_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctrlOn;
  logic freqOn;
  // enabling writes; only these may turn a driver on
  assign ctrlOn = psel && penable && pready && pwrite && paddr == 8'h00
                  && pwdata[1];
  assign freqOn = psel && penable && pready && pwrite && paddr == 8'h10
                  && pwdata[6];
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (pready && paddr <= 8'h14
      && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  a_read_zero: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_cnt_oe_cause: assert property (
      $rose(counter1_result_oe) |-> $past(ctrlOn) || $past(ctrlOn, 2))
    else $error("counter driver on without enabling write");
  a_div_oe_cause: assert property (
      $rose(divided_clock_oe) |-> $past(freqOn) || $past(freqOn, 2))
    else $error("divider driver on without enabling write");
  // main scenarios
  c_refused: cover property (pready && pslverr);
  c_cnt_out: cover property ($rose(counter1_result_output));
  c_div_out: cover property ($rose(divided_clock_output));
endmodule
bind gp_counter_output_freq_divider gpc_output_checker u_chk (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .counter1_result_output, .counter1_result_oe,
  .divided_clock_output, .divided_clock_oe
);
`default_nettype wire

// File: tb/field_model.sv
/*
  field signals on the connector: source clock, gate and direction line.
  assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module field_model (
  // clock
  input  wire logic clk,
  // pins toward the device
  output var  logic srcPin,
  output var  logic gatePin,
  output var  logic dioPin
);
  // source stands still between steps, like a real gated clock
  initial begin
    srcPin = 1'b0;
    gatePin = 1'b0;
    dioPin = 1'b0;
  end
  // one source level change, then time for the 3-flop sync path
  task automatic step(input logic v);
    srcPin <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic setDio(input logic v);
    dioPin <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic setGate(input logic v);
    gatePin <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
  self-checking bench: apb tasks, divider and counter scenarios.
  assumes field_model drives the pins and the checker is bound.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        srcPin, gatePin, dioPin, resOut, resOe, divOut, divOe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          mismatches, nTests, n;

  gp_counter_output_freq_divider u_dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .counter1_clock_source  (srcPin),
    .counter1_gate_input    (gatePin),
    .digital_line_seven     (dioPin),
    .counter1_result_output (resOut),
    .counter1_result_oe     (resOe),
    .divided_clock_output   (divOut),
    .divided_clock_oe       (divOe)
  );
  field_model u_fld (
    .clk     (clk),
    .srcPin  (srcPin),
    .gatePin (gatePin),
    .dioPin  (dioPin)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, y);
    nTests++;
    if (y !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, y);
      mismatches++;
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      summarize();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  task automatic doReset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // rising edges of the divided clock over len cycles
  task automatic rises(input int len);
    logic p;
    n = 0;
    repeat (500) @(posedge clk);
    p = divOut;
    repeat (len) begin
      @(posedge clk);
      if (divOut === 1'b1 && p === 1'b0) n++;
      p = divOut;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    nTests = 0;
    @(posedge clk);
    doReset();
    chk("cnt oe", 1'b0, resOe);
    chk("div oe", 1'b0, divOe);
    rdc("ctrl reset", 8'h00, 32'h10);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1'b1, e);
    chk("unmapped read", 32'h0, q);
    // divider: code+1 cycles per period, then both ends of the range
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h10, 32'h40 | ((2 << i) - 1));
      rises(32 << i);
      chk("div rises", 16, n);
    end
    chk("div oe on", 1'b1, divOe);
    apb(1'b1, 8'h10, 32'h51);
    rises(800);
    chk("slow rises", 4, n);
    apb(1'b1, 8'h10, 32'h40);
    rises(1);
    chk("div by one", 1'b1, divOut);
    apb(1'b1, 8'h10, 32'h60);
    rises(1);
    chk("div pol", 1'b0, divOut);
    // output modes: bit0 toggle, bit1 polarity; load 1 counting down,
    // terminal count falls on the step taken from zero
    for (int m = 0; m < 4; m++) begin
      doReset();
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h00, 32'h213 | (m << 2));
      @(posedge clk); // enable flop loads on the edge the task returns at
      chk("oe on", 1'b1, resOe);
      u_fld.step(1'b1);
      u_fld.step(1'b0);
      chk("out idle", m[1], resOut);
      u_fld.step(1'b1);
      u_fld.step(1'b0);
      chk("out at tc", !m[1], resOut);
      u_fld.step(1'b1);
      u_fld.step(1'b0);
      chk("out after", m[0] ? !m[1] : m[1], resOut);
    end
    // direction from pin, then from software, then falling edges
    apb(1'b1, 8'h04, 32'hA);
    apb(1'b1, 8'h00, 32'h211);
    repeat (3) begin
      u_fld.step(1'b1);
      u_fld.step(1'b0);
    end
    rdc("count down", 8'h08, 32'h7);
    u_fld.setDio(1'b1);
    repeat (3) begin
      u_fld.step(1'b1);
      u_fld.step(1'b0);
    end
    rdc("count up", 8'h08, 32'hA);
    u_fld.setDio(1'b0);
    apb(1'b1, 8'h00, 32'h221);
    u_fld.step(1'b1);
    u_fld.step(1'b0);
    rdc("soft up", 8'h08, 32'hB);
    apb(1'b1, 8'h00, 32'h261);
    u_fld.step(1'b1);
    rdc("rise ignored", 8'h08, 32'hB);
    u_fld.step(1'b0);
    rdc("fall counted", 8'h08, 32'hC);
    apb(1'b1, 8'h00, 32'hE61);
    u_fld.setGate(1'b1);
    // the gate is only looked at on an active source edge
    u_fld.step(1'b1);
    u_fld.step(1'b0);
    rdc("gate save", 8'h0C, 32'hC);
    rdc("count on", 8'h08, 32'hD);
    rdc("status", 8'h14, 32'hB);
    apb(1'b1, 8'h14, 32'h3);
    rdc("status clr", 8'h14, 32'h8);
    // level gate on the fast internal source: one count per clock
    u_fld.setGate(1'b0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h421);
    rdc("gate held", 8'h08, 32'h0);
    u_fld.setGate(1'b1);
    u_fld.setGate(1'b0);
    rdc("gate level", 8'h08, 32'h8);
    summarize();
  end
endmodule
`default_nettype wire
